/* File: core/port_slice.sv */
/*
  One 8-bit bidirectional port with per-bit pull-up. Pin outputs are
  flops cleared at once by the raw reset pin, without a clock.
  Assumes pin inputs synchronous to aclk.
*/
`timescale 1ns/1ps
`default_nettype none

`include "sleep_ctrl_defines.svh"

module port_slice (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ext_reset_n,
  input wire logic ce,
  input wire logic rst_hold,
  input wire logic [23:0] cfg,
  input wire logic [7:0] pins_in,
  output sleep_ctrl_pkg::pin_group_t pins,
  output logic [7:0] pins_sample
);

  sleep_ctrl_pkg::pin_group_t pins_d;

  // ----------------------------------------------------------------------
  // Next pin drive
  // ----------------------------------------------------------------------
  // Tri-state and no pull-up while any reset holds
  always_comb begin
    pins_d = '0;
    if (!rst_hold) begin
      pins_d.o = cfg[`CFG_OUT_LSB +: 8];
      pins_d.oe = cfg[`CFG_DIR_LSB +: 8];
      pins_d.pu = cfg[`CFG_PU_LSB +: 8] & ~cfg[`CFG_DIR_LSB +: 8];
    end
  end

  // Raw pin clears drive with no clock running
  always_ff @(posedge aclk or negedge ext_reset_n) begin
    if (!ext_reset_n) begin
      pins <= '0;
      pins_sample <= 8'h00;
    end else if (!aresetn) begin
      pins <= '0;
      pins_sample <= 8'h00;
    end else if (ce) begin
      pins <= pins_d;
      pins_sample <= pins_in;
    end
  end

endmodule

`default_nettype wire

/* File: core/sleep_ctrl_defines.svh */
/*
  Offsets, field positions, reset values and timing counts of the sleep
  and reset controller. Assumes a 100 MHz aclk and a byte-addressed
  AXI4-Lite register window of 256 bytes.
*/
`ifndef SLEEP_CTRL_DEFINES_SVH
`define SLEEP_CTRL_DEFINES_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define CTRL_OFS 8'h00
`define STATUS_OFS 8'h04
`define PORT_CFG_BASE 8'h10
`define PORT_IN_BASE 8'h20
`define PORT_GROUP_MASK 8'hF0

// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define CTRL_SE_BIT 0
`define CTRL_MODE_LSB 1
`define CTRL_GO_BIT 4
`define CTRL_SE_RESET 1'h0
`define STAT_STATE_LSB 0
`define STAT_GATE_LSB 3
`define STAT_MODE_LSB 8
`define STAT_SE_BIT 11
`define CFG_OUT_LSB 0
`define CFG_DIR_LSB 8
`define CFG_PU_LSB 16
`define PORT_CFG_RESET 24'h000000

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CLK_PERIOD_NS 10
`define RST_MIN_PULSE_NS 2500
`define RST_MIN_CYC ((`RST_MIN_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WAKE_SETTLE_NS 1000
`define WAKE_SETTLE_CYC ((`WAKE_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// ----------------------------------------------------------------------
// Bus answers
// ----------------------------------------------------------------------
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

/* File: core/sleep_ctrl_pkg.sv */
/*
  Types of the sleep and reset controller: sleep modes, controller
  states and the packed carriers for clock gates and port pins.
  Assumes the constants of sleep_ctrl_defines.svh.
*/
package sleep_ctrl_pkg;

  // Software selectable sleep modes
  typedef enum logic [2:0] {
    MODE_IDLE = 3'h0,
    MODE_ADC_NR = 3'h1,
    MODE_PDOWN = 3'h2,
    MODE_PSAVE = 3'h3,
    MODE_STANDBY = 3'h4,
    MODE_EXT_STANDBY = 3'h5
  } mode_t;

  // Controller states, one-hot
  typedef enum logic [2:0] {
    ST_RUN = 3'b001,
    ST_SLEEP = 3'b010,
    ST_WAKE = 3'b100
  } run_state_t;

  // Clock enables of each domain
  typedef struct packed {
    logic cpu;
    logic io;
    logic adc;
    logic asy;
    logic osc;
  } clk_gate_t;

  // One 8-bit port: drive value, output enable, pull-up enable
  typedef struct packed {
    logic [7:0] o;
    logic [7:0] oe;
    logic [7:0] pu;
  } pin_group_t;

endpackage

/* File: core/sleep_mode_clock_gating.sv */
/*
  Sleep mode and reset controller: gates the processor, I/O, converter,
  asynchronous timer and oscillator clocks per sleep mode, wakes on an
  interrupt, filters the external reset pin and owns four 8-bit ports.
  Assumes an AXI4-Lite master, 100 MHz aclk, synchronous pin inputs.
*/
// Contract
// - Idle stops the processor clock; memory, timers, serial and interrupts run.
// - Power-down keeps registers, stops oscillator and all else until interrupt or reset.
// - Power-save keeps the asynchronous timer running, rest asleep.
// - Converter noise reduction stops processor and I/O except asynchronous timer and converter.
// - Standby keeps the main oscillator running, everything else asleep.
// - Extended standby keeps main oscillator and asynchronous timer running.
// - Exactly six software-selected sleep modes exist.
// - Any active reset tri-states every pin of all four ports, even clockless; aresetn clears them only on an aclk edge.
// - Reset pin low beyond minimum width resets; source must hold it that long.
// - Each port is 8-bit bidirectional with per-bit pull-up enable.
`timescale 1ns/1ps
`default_nettype none

`include "sleep_ctrl_defines.svh"

module sleep_mode_clock_gating (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic ext_reset_n,
  input wire logic wake_irq,
  input wire logic oscillator_input_pin,
  output logic oscillator_output_pin,
  output sleep_ctrl_pkg::clk_gate_t clk_gates,
  output logic core_reset_n,
  input wire logic [7:0] first_port_pins_in,
  input wire logic [7:0] second_port_pins_in,
  input wire logic [7:0] third_port_pins_in,
  input wire logic [7:0] fourth_port_pins_in,
  output sleep_ctrl_pkg::pin_group_t first_port_pins,
  output sleep_ctrl_pkg::pin_group_t second_port_pins,
  output sleep_ctrl_pkg::pin_group_t third_port_pins,
  output sleep_ctrl_pkg::pin_group_t fourth_port_pins
);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  logic aw_hold_q, aw_hold_d, w_hold_q, w_hold_d;
  logic [7:0] awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d;
  logic [3:0] wstrb_q, wstrb_d;
  logic awready_d, wready_d, bvalid_d, arready_d, rvalid_d;
  logic [1:0] bresp_d, rresp_d;
  logic [31:0] rdata_d;
  logic wr_fire, ctrl_wr, mode_ok;
  logic [7:0] rst_cnt_q, rst_cnt_d, wake_cnt_q, wake_cnt_d;
  logic core_rst_n_d, rst_any, se_q, se_d, osc_out_d;
  sleep_ctrl_pkg::run_state_t state_q, state_d;
  sleep_ctrl_pkg::mode_t mode_q, mode_d;
  sleep_ctrl_pkg::clk_gate_t gate_d;
  logic [23:0] cfg_q [4];
  logic [23:0] cfg_d [4];
  logic [7:0] pin_in_arr [4];
  logic [7:0] sample_arr [4];
  sleep_ctrl_pkg::pin_group_t pins_arr [4];

  assign rst_any = !aresetn || !core_reset_n;
  assign wr_fire = aw_hold_q && w_hold_q && !s_axi_bvalid;
  assign mode_ok = wdata_q[`CTRL_MODE_LSB +: 3] <= sleep_ctrl_pkg::MODE_EXT_STANDBY;
  assign ctrl_wr = wr_fire && awaddr_q == `CTRL_OFS && wstrb_q[0]
                   && state_q == sleep_ctrl_pkg::ST_RUN;

  // Clock enables per controller state and mode
  function automatic sleep_ctrl_pkg::clk_gate_t gates_for(
    input sleep_ctrl_pkg::run_state_t st,
    input sleep_ctrl_pkg::mode_t md
  );
    sleep_ctrl_pkg::clk_gate_t g;
    g = '{cpu: 1'b1, io: 1'b1, adc: 1'b1, asy: 1'b1, osc: 1'b1};
    if (st == sleep_ctrl_pkg::ST_SLEEP) begin
      // Field order cpu, io, adc, asy, osc
      unique case (md)
        sleep_ctrl_pkg::MODE_IDLE: g = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
        sleep_ctrl_pkg::MODE_ADC_NR: g = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
        sleep_ctrl_pkg::MODE_PDOWN: g = '0;
        sleep_ctrl_pkg::MODE_PSAVE: g = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
        sleep_ctrl_pkg::MODE_STANDBY: g = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
        sleep_ctrl_pkg::MODE_EXT_STANDBY: g = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
        default: g = '0;
      endcase
    end else if (st == sleep_ctrl_pkg::ST_WAKE) begin
      g.cpu = 1'b0;
    end
    return g;
  endfunction

  // ----------------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------------
  // Address and data taken in either order, answer once both are held
  always_comb begin
    aw_hold_d = aw_hold_q;
    w_hold_d = w_hold_q;
    awaddr_d = awaddr_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    awready_d = s_axi_awready;
    wready_d = s_axi_wready;
    bvalid_d = s_axi_bvalid;
    bresp_d = s_axi_bresp;
    arready_d = s_axi_arready;
    rvalid_d = s_axi_rvalid;
    rresp_d = s_axi_rresp;
    rdata_d = s_axi_rdata;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_hold_d = 1'b1;
      awaddr_d = s_axi_awaddr;
      awready_d = 1'b0;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_hold_d = 1'b1;
      wdata_d = s_axi_wdata;
      wstrb_d = s_axi_wstrb;
      wready_d = 1'b0;
    end
    if (wr_fire) begin
      aw_hold_d = 1'b0;
      w_hold_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = (awaddr_q == `CTRL_OFS || awaddr_q == `STATUS_OFS
                 || (awaddr_q & `PORT_GROUP_MASK) == `PORT_CFG_BASE
                 || (awaddr_q & `PORT_GROUP_MASK) == `PORT_IN_BASE)
                ? `RESP_OKAY : `RESP_SLVERR;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      bvalid_d = 1'b0;
      awready_d = 1'b1;
      wready_d = 1'b1;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      arready_d = 1'b0;
      rvalid_d = 1'b1;
      rresp_d = `RESP_OKAY;
      rdata_d = 32'h00000000;
      if (s_axi_araddr == `CTRL_OFS) begin
        rdata_d[`CTRL_SE_BIT] = se_q;
        rdata_d[`CTRL_MODE_LSB +: 3] = mode_q;
      end else if (s_axi_araddr == `STATUS_OFS) begin
        rdata_d[`STAT_STATE_LSB +: 3] = state_q;
        rdata_d[`STAT_GATE_LSB +: 5] = clk_gates;
        rdata_d[`STAT_MODE_LSB +: 3] = mode_q;
        rdata_d[`STAT_SE_BIT] = se_q;
      end else if ((s_axi_araddr & `PORT_GROUP_MASK) == `PORT_CFG_BASE) begin
        rdata_d[23:0] = cfg_q[s_axi_araddr[3:2]];
      end else if ((s_axi_araddr & `PORT_GROUP_MASK) == `PORT_IN_BASE) begin
        rdata_d[7:0] = sample_arr[s_axi_araddr[3:2]];
      end else begin
        rresp_d = `RESP_SLVERR;
      end
    end
    if (s_axi_rvalid && s_axi_rready) begin
      rvalid_d = 1'b0;
      arready_d = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= `RESP_OKAY;
      s_axi_rdata <= 32'h00000000;
    end else if (ce) begin
      aw_hold_q <= aw_hold_d;
      w_hold_q <= w_hold_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      s_axi_awready <= awready_d;
      s_axi_wready <= wready_d;
      s_axi_bvalid <= bvalid_d;
      s_axi_bresp <= bresp_d;
      s_axi_arready <= arready_d;
      s_axi_rvalid <= rvalid_d;
      s_axi_rresp <= rresp_d;
      s_axi_rdata <= rdata_d;
    end
  end

  // ----------------------------------------------------------------------
  // Reset pin filter
  // ----------------------------------------------------------------------
  // Short pulses are dropped; a long one holds the core in reset
  always_comb begin
    rst_cnt_d = 8'h00;
    core_rst_n_d = 1'b1;
    if (!ext_reset_n) begin
      if (rst_cnt_q == 8'(`RST_MIN_CYC - 1)) begin
        rst_cnt_d = rst_cnt_q;
        core_rst_n_d = 1'b0;
      end else begin
        rst_cnt_d = rst_cnt_q + 8'h01;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rst_cnt_q <= 8'h00;
      core_reset_n <= 1'b1;
    end else if (ce) begin
      rst_cnt_q <= rst_cnt_d;
      core_reset_n <= core_rst_n_d;
    end
  end

  // ----------------------------------------------------------------------
  // Sleep state machine and clock gates
  // ----------------------------------------------------------------------
  // Enter sleep on a go write with sleep enable and a legal mode, wake on interrupt, settle, then run
  always_comb begin
    state_d = state_q;
    mode_d = mode_q;
    se_d = se_q;
    wake_cnt_d = wake_cnt_q;
    unique case (state_q)
      sleep_ctrl_pkg::ST_RUN: begin
        if (ctrl_wr) begin
          se_d = wdata_q[`CTRL_SE_BIT];
          if (mode_ok) begin
            mode_d = sleep_ctrl_pkg::mode_t'(wdata_q[`CTRL_MODE_LSB +: 3]);
            if (wdata_q[`CTRL_GO_BIT] && wdata_q[`CTRL_SE_BIT]) begin
              state_d = sleep_ctrl_pkg::ST_SLEEP;
            end
          end
        end
      end
      sleep_ctrl_pkg::ST_SLEEP: begin
        wake_cnt_d = 8'h00;
        if (wake_irq) begin
          state_d = sleep_ctrl_pkg::ST_WAKE;
        end
      end
      sleep_ctrl_pkg::ST_WAKE: begin
        wake_cnt_d = wake_cnt_q + 8'h01;
        if (wake_cnt_q == 8'(`WAKE_SETTLE_CYC - 1)) begin
          state_d = sleep_ctrl_pkg::ST_RUN;
        end
      end
    endcase
    gate_d = gates_for(state_d, mode_d);
    osc_out_d = gate_d.osc && !oscillator_input_pin;
  end

  always_ff @(posedge aclk) begin
    if (rst_any) begin
      state_q <= sleep_ctrl_pkg::ST_RUN;
      mode_q <= sleep_ctrl_pkg::MODE_IDLE;
      se_q <= `CTRL_SE_RESET;
      wake_cnt_q <= 8'h00;
      clk_gates <= '{cpu: 1'b1, io: 1'b1, adc: 1'b1, asy: 1'b1, osc: 1'b1};
      oscillator_output_pin <= 1'b0;
    end else if (ce) begin
      state_q <= state_d;
      mode_q <= mode_d;
      se_q <= se_d;
      wake_cnt_q <= wake_cnt_d;
      clk_gates <= gate_d;
      oscillator_output_pin <= osc_out_d;
    end
  end

  // ----------------------------------------------------------------------
  // Port configuration and ports
  // ----------------------------------------------------------------------
  // Byte-lane writes into each port word
  always_comb begin
    for (int p = 0; p < 4; p++) begin
      cfg_d[p] = cfg_q[p];
      if (wr_fire && awaddr_q == `PORT_CFG_BASE + 8'(4 * p)) begin
        for (int b = 0; b < 3; b++) begin
          if (wstrb_q[b]) begin
            cfg_d[p][8 * b +: 8] = wdata_q[8 * b +: 8];
          end
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    for (int p = 0; p < 4; p++) begin
      if (rst_any) begin
        cfg_q[p] <= `PORT_CFG_RESET;
      end else if (ce) begin
        cfg_q[p] <= cfg_d[p];
      end
    end
  end

  assign pin_in_arr[0] = first_port_pins_in;
  assign pin_in_arr[1] = second_port_pins_in;
  assign pin_in_arr[2] = third_port_pins_in;
  assign pin_in_arr[3] = fourth_port_pins_in;

  // One port slice per port
  for (genvar p = 0; p < 4; p++) begin : g_port
    port_slice u_port (
      .aclk(aclk),
      .aresetn(aresetn),
      .ext_reset_n(ext_reset_n),
      .ce(ce),
      .rst_hold(rst_any),
      .cfg(cfg_q[p]),
      .pins_in(pin_in_arr[p]),
      .pins(pins_arr[p]),
      .pins_sample(sample_arr[p])
    );
  end

  assign first_port_pins = pins_arr[0];
  assign second_port_pins = pins_arr[1];
  assign third_port_pins = pins_arr[2];
  assign fourth_port_pins = pins_arr[3];

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  wire in_sleep = state_q == sleep_ctrl_pkg::ST_SLEEP;

  sequence s_wake_start;
    in_sleep && wake_irq && ce && !rst_any;
  endsequence

  sequence s_restored;
    state_q == sleep_ctrl_pkg::ST_WAKE && clk_gates.osc && clk_gates.io
      && clk_gates.asy && !clk_gates.cpu;
  endsequence

  idle_gates_a: assert property (in_sleep && mode_q == sleep_ctrl_pkg::MODE_IDLE |->
    !clk_gates.cpu && clk_gates.io && clk_gates.osc) else $error("idle gates wrong");
  pdown_gates_a: assert property (in_sleep && mode_q == sleep_ctrl_pkg::MODE_PDOWN |->
    clk_gates == '0) else $error("power-down gates wrong");
  psave_timer_a: assert property (in_sleep && mode_q == sleep_ctrl_pkg::MODE_PSAVE |->
    clk_gates.asy && !clk_gates.osc && !clk_gates.io) else $error("power-save gates wrong");
  adc_noise_a: assert property (in_sleep && mode_q == sleep_ctrl_pkg::MODE_ADC_NR |->
    clk_gates.adc && clk_gates.asy && !clk_gates.io && !clk_gates.cpu)
    else $error("noise reduction gates wrong");
  standby_osc_a: assert property (in_sleep && mode_q == sleep_ctrl_pkg::MODE_STANDBY |->
    clk_gates.osc && !clk_gates.asy && !clk_gates.io) else $error("standby gates wrong");
  ext_standby_a: assert property (in_sleep &&
    mode_q == sleep_ctrl_pkg::MODE_EXT_STANDBY |->
    clk_gates.osc && clk_gates.asy && !clk_gates.cpu) else $error("ext standby gates wrong");
  mode_legal_a: assert property (ctrl_wr && ce && !rst_any && !mode_ok |=>
    $stable(mode_q) && state_q == sleep_ctrl_pkg::ST_RUN) else $error("illegal mode taken");
  reset_tristate_a: assert property (rst_any && ce |=>
    first_port_pins.oe == 8'h00 && second_port_pins.oe == 8'h00
    && third_port_pins.oe == 8'h00 && fourth_port_pins.oe == 8'h00)
    else $error("port driven in reset");
  reset_filter_a: assert property (!ext_reset_n && ce && rst_cnt_q == 8'(`RST_MIN_CYC - 1)
    |=> !core_reset_n) else $error("long reset pulse missed");
  pullup_bits_a: assert property (ce && !rst_any && ext_reset_n |=> !ext_reset_n
    || second_port_pins.pu == ($past(cfg_q[1][`CFG_PU_LSB +: 8])
    & ~$past(cfg_q[1][`CFG_DIR_LSB +: 8])))
    else $error("pull-up mismatch");
  wake_order_a: assert property (s_wake_start |=> s_restored)
    else $error("clocks not restored on wake");
  cpu_last_a: assert property (clk_gates.cpu && !rst_any |->
    state_q == sleep_ctrl_pkg::ST_RUN) else $error("processor clocked outside run");

endmodule

`default_nettype wire

/* File: sim/pin_board.sv */
/*
  Board-side model: external reset source and the pins of four ports.
  Assumes the bench commands reset pulses and reads the pin levels back.
*/
`timescale 1ns/1ps
`default_nettype none

module pin_board (
  input wire logic aclk,
  input wire logic rst_go,
  input wire logic [9:0] rst_len,
  input wire sleep_ctrl_pkg::pin_group_t [3:0] grp,
  output logic ext_reset_n,
  output logic [3:0][7:0] lvl
);
  logic [9:0] cnt_q = 10'h000;
  logic flip_q = 1'b0;

  // ------------------------------------------------------------
  // Reset source
  // ------------------------------------------------------------
  // Holds the pin low for the whole commanded length
  always @(posedge aclk) begin
    flip_q <= ~flip_q;
    if (rst_go) begin
      cnt_q <= rst_len;
    end else if (cnt_q != 10'h000) begin
      cnt_q <= cnt_q - 10'h001;
    end
  end
  assign ext_reset_n = (cnt_q == 10'h000);

  // ------------------------------------------------------------
  // Pin levels
  // ------------------------------------------------------------
  // Driven bits, else pull-up, else a floating toggle
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      lvl[i] = (grp[i].oe & grp[i].o) | (~grp[i].oe & grp[i].pu)
        | (~grp[i].oe & ~grp[i].pu & {8{flip_q}});
    end
  end
endmodule

`default_nettype wire

/* File: sim/sleep_mode_clock_gating_bench.sv */
/*
  Self-checking bench of the sleep and reset controller.
  Assumes the design files and pin_board are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none

`include "sleep_ctrl_defines.svh"

module sleep_mode_clock_gating_bench;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic ce = 1'b1;
  logic [7:0] aw = 8'h00;
  logic [7:0] ar = 8'h00;
  logic [31:0] wd = 32'h0;
  logic [3:0] ws = 4'h0;
  logic awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
  logic wake = 1'b0, osc_in = 1'b0, rst_go = 1'b0, osc_prev = 1'b0;
  logic [9:0] rst_len = 10'h000;
  logic awr, wr_rdy, bv, arr, rv, osc_out, crst_n, ext_n;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  sleep_ctrl_pkg::clk_gate_t gates;
  sleep_ctrl_pkg::pin_group_t [3:0] pins;
  logic [3:0][7:0] lvl;
  logic [33:0] exp_q[$];
  logic [31:0] seed = 32'h00013D2C;
  logic [31:0] cfg [4];
  logic [4:0] gtab [6] = '{5'h0F, 5'h07, 5'h00, 5'h02, 5'h01, 5'h03};
  int fails = 0;
  int compares = 0;

  always #5 aclk = ~aclk;

  sleep_mode_clock_gating sleep_mode_clock_gating_i (
    .aclk(aclk), .aresetn(aresetn), .ce(ce),
    .s_axi_awaddr(aw), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wr_rdy),
    .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
    .s_axi_araddr(ar), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr),
    .ext_reset_n(ext_n), .wake_irq(wake), .oscillator_input_pin(osc_in),
    .oscillator_output_pin(osc_out), .clk_gates(gates), .core_reset_n(crst_n),
    .first_port_pins_in(lvl[0]), .second_port_pins_in(lvl[1]),
    .third_port_pins_in(lvl[2]), .fourth_port_pins_in(lvl[3]),
    .first_port_pins(pins[0]), .second_port_pins(pins[1]),
    .third_port_pins(pins[2]), .fourth_port_pins(pins[3])
  );

  pin_board pin_board_i (
    .aclk(aclk), .rst_go(rst_go), .rst_len(rst_len), .grp(pins),
    .ext_reset_n(ext_n), .lvl(lvl)
  );

  // ------------------------------------------------------------
  // Checking and closing
  // ------------------------------------------------------------
  task automatic chk(input logic [33:0] seen, input logic [33:0] want);
    compares++;
    if (seen !== want) begin
      fails++;
      $display("[ERR] %0t seen %h want %h", $time, seen, want);
    end
  endtask

  task automatic end_sim();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Bus answers compared against the oldest note
  always @(negedge aclk) begin
    if (bv && br) chk({bresp, 32'h0}, exp_q.pop_front());
    if (rv && rr) chk({rresp, rdata}, exp_q.pop_front());
  end

  // Next step of the random source
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Random oscillator input and the level the design last sampled
  always @(posedge aclk) begin
    seed <= lfsr(seed);
    osc_in <= seed[0];
    osc_prev <= osc_in;
  end

  // ------------------------------------------------------------
  // Bus master tasks
  // ------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    logic a_ok, w_ok, b_ok;
    exp_q.push_back({r, 32'h0});
    @(posedge aclk);
    aw <= a;
    awv <= 1'b1;
    wd <= d;
    ws <= 4'hF;
    wv <= 1'b1;
    br <= 1'b1;
    b_ok = 1'b0;
    while (!b_ok) begin
      @(negedge aclk);
      a_ok = awv && awr;
      w_ok = wv && wr_rdy;
      b_ok = bv;
      @(posedge aclk);
      if (a_ok) awv <= 1'b0;
      if (w_ok) wv <= 1'b0;
    end
    br <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    logic r_ok;
    exp_q.push_back({r, d});
    @(posedge aclk);
    ar <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    r_ok = 1'b0;
    while (!r_ok) begin
      @(negedge aclk);
      r_ok = rv;
      @(posedge aclk);
      if (arv && arr) arv <= 1'b0;
    end
    arv <= 1'b0;
    rr <= 1'b0;
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`STATUS_OFS, 32'h000000F9, `RESP_OKAY);
    // Ports with random drive and direction, pull-ups on the rest
    for (int i = 0; i < 4; i++) begin
      cfg[i] = {8'h00, ~seed[15:8], seed[15:8], seed[7:0]};
      wr(`PORT_CFG_BASE + 8'(4 * i), cfg[i], `RESP_OKAY);
      repeat (4) @(posedge aclk);
      chk({10'h0, pins[i]}, {10'h0, cfg[i][7:0], cfg[i][15:8], cfg[i][23:16]});
      rd(`PORT_IN_BASE + 8'(4 * i), {24'h0, cfg[i][7:0] & cfg[i][15:8] | cfg[i][23:16]},
        `RESP_OKAY);
    end
    $display("ports done");
    // Every sleep mode, then wake
    for (int m = 0; m < 6; m++) begin
      wr(`CTRL_OFS, {27'h0, 1'b1, 3'(m), 1'b1}, `RESP_OKAY);
      chk({29'h0, gates}, {29'h0, gtab[m]});
      chk({33'h0, osc_out}, {33'h0, gtab[m][0] & ~osc_prev});
      rd(`STATUS_OFS, {20'h0, 1'b1, 3'(m), gtab[m], 3'h2}, `RESP_OKAY);
      wake <= 1'b1;
      @(posedge aclk);
      wake <= 1'b0;
      repeat (50) @(posedge aclk);
      chk({29'h0, gates}, {29'h0, 5'h0F});
      repeat (60) @(posedge aclk);
      chk({29'h0, gates}, {29'h0, 5'h1F});
    end
    wr(`CTRL_OFS, 32'h0000001D, `RESP_OKAY);
    chk({29'h0, gates}, {29'h0, 5'h1F});
    // Go without sleep enable stores the mode and clears sleep enable
    wr(`CTRL_OFS, 32'h00000014, `RESP_OKAY);
    chk({29'h0, gates}, {29'h0, 5'h1F});
    chk({33'h0, osc_out}, {33'h0, ~osc_prev});
    rd(`STATUS_OFS, 32'h000002F9, `RESP_OKAY);
    rd(`PORT_CFG_BASE, cfg[0], `RESP_OKAY);
    wr(8'h30, 32'hFFFFFFFF, `RESP_SLVERR);
    rd(8'h30, 32'h0, `RESP_SLVERR);
    $display("modes done");
    // Short reset pulse, clock enable off until the pins are checked
    ce <= 1'b0;
    rst_go <= 1'b1;
    rst_len <= 10'h064;
    @(posedge aclk);
    rst_go <= 1'b0;
    repeat (10) @(posedge aclk);
    chk({2'h0, pins[0].oe, pins[1].oe, pins[2].oe, pins[3].oe}, 34'h0);
    ce <= 1'b1;
    repeat (100) @(posedge aclk);
    chk({33'h0, crst_n}, 34'h1);
    // Long pulse resets the core and the port setup
    rst_go <= 1'b1;
    rst_len <= 10'h12C;
    @(posedge aclk);
    rst_go <= 1'b0;
    repeat (270) @(posedge aclk);
    chk({33'h0, crst_n}, 34'h0);
    repeat (40) @(posedge aclk);
    rd(`PORT_CFG_BASE, 32'h0, `RESP_OKAY);
    $display("resets done");
    end_sim();
  end

  // Watchdog
  initial begin
    #200000;
    fails++;
    end_sim();
  end
endmodule

`default_nettype wire
